// *** core/dpa_ctrl.sv ***
// Controller end: issues one command per request and keeps the bank spacing.
// Assumes the user holds a request until ready; one clock with the device.
module dpa_ctrl
  import dpa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  dpa_cmd_if.ctrl cmd,
  input wire logic req_valid_i,
  input wire logic [2:0] req_cmd_i,
  input wire logic [BANK_W-1:0] req_bank_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_ap_i,
  input wire logic [3:0] cl_i,
  input wire logic [3:0] al_i,
  input wire logic bl8_i,
  output logic req_ready_o
);
  import dpa_pkg::*;
  typedef struct packed {
    logic [NUM_BANKS-1:0] open;
    logic [NUM_BANKS-1:0][CNT_W-1:0] pre_ok;
    logic [NUM_BANKS-1:0][CNT_W-1:0] act_ok;
    logic [NUM_BANKS-1:0][CNT_W-1:0] rw_ok;
    logic cs_n;
    logic [2:0] code;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } dpa_ctrl_s;
  dpa_ctrl_s st_r;
  dpa_ctrl_s st_nxt;
  logic legal;
  logic [CNT_W-1:0] hb;
  logic [CNT_W-1:0] rd_pre;
  logic [CNT_W-1:0] wr_pre;
  logic [CNT_W-1:0] rd_ap_act;
  logic [CNT_W-1:0] all_pre_ok;
  assign hb = dpa_half_bl(bl8_i);
  assign rd_pre = dpa_rl(al_i, 4'h0) + hb + dpa_max(CNT_W'(RTP_CYC), CNT_W'(2))
                  - CNT_W'(2);
  assign wr_pre = dpa_wl(al_i, cl_i) + hb + CNT_W'(WR_CYC);
  assign rd_ap_act = dpa_max(rd_pre, CNT_W'(al_i) + hb) + CNT_W'(RP_CYC);
  always_comb
  begin
    all_pre_ok = '0;
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      all_pre_ok = dpa_max(all_pre_ok, st_r.pre_ok[b]);
    end
  end
  // ==========================================================================
  // Legality of the waiting request
  always_comb
  begin
    case (req_cmd_i)
      DPA_CMD_ACT: legal = !st_r.open[req_bank_i] && st_r.act_ok[req_bank_i] == '0;
      DPA_CMD_RD, DPA_CMD_WR: legal = st_r.open[req_bank_i] && st_r.rw_ok[req_bank_i] == '0;
      DPA_CMD_PRE: legal = req_ap_i ? all_pre_ok == '0 : st_r.pre_ok[req_bank_i] == '0;
      default: legal = 1'b1;
    endcase
  end
  assign req_ready_o = legal;
  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cs_n = 1'b1;
    st_nxt.code = DPA_CMD_NOP;
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      if (st_r.pre_ok[b] != '0) st_nxt.pre_ok[b] = st_r.pre_ok[b] - CNT_W'(1);
      if (st_r.act_ok[b] != '0) st_nxt.act_ok[b] = st_r.act_ok[b] - CNT_W'(1);
      if (st_r.rw_ok[b] != '0) st_nxt.rw_ok[b] = st_r.rw_ok[b] - CNT_W'(1);
    end
    if (req_valid_i && legal)
    begin
      st_nxt.cs_n = 1'b0;
      st_nxt.code = req_cmd_i;
      st_nxt.ba = req_bank_i;
      st_nxt.addr = req_addr_i;
      st_nxt.addr[AP_BIT] = req_ap_i;
      case (req_cmd_i)
        DPA_CMD_ACT:
        begin
          st_nxt.open[req_bank_i] = 1'b1;
          st_nxt.pre_ok[req_bank_i] = CNT_W'(RAS_CYC - 1);
          st_nxt.act_ok[req_bank_i] = CNT_W'(RC_CYC - 1);
          st_nxt.rw_ok[req_bank_i] = CNT_W'(RCD_CYC - 1);
        end
        DPA_CMD_RD:
        begin
          st_nxt.pre_ok[req_bank_i] = dpa_max(st_r.pre_ok[req_bank_i], rd_pre - CNT_W'(1));
          if (req_ap_i)
          begin
            st_nxt.open[req_bank_i] = 1'b0;
            st_nxt.act_ok[req_bank_i] = dpa_max(st_r.act_ok[req_bank_i],
                                                rd_ap_act - CNT_W'(1));
          end
        end
        DPA_CMD_WR:
        begin
          st_nxt.pre_ok[req_bank_i] = dpa_max(st_r.pre_ok[req_bank_i], wr_pre - CNT_W'(1));
          if (req_ap_i)
          begin
            st_nxt.open[req_bank_i] = 1'b0;
            st_nxt.act_ok[req_bank_i] = dpa_max(st_r.act_ok[req_bank_i],
                                                wr_pre + CNT_W'(RP_CYC - 1));
          end
        end
        DPA_CMD_PRE:
        begin
          for (int b = 0; b < NUM_BANKS; b++)
          begin
            if (req_ap_i || BANK_W'(b) == req_bank_i)
            begin
              st_nxt.open[b] = 1'b0;
              st_nxt.act_ok[b] = dpa_max(st_r.act_ok[b], CNT_W'(RP_CYC - 1));
            end
          end
        end
        default: st_nxt.cs_n = 1'b1;
      endcase
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_r <= '0;
      st_r.cs_n <= 1'b1;
      st_r.code <= DPA_CMD_NOP;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  assign cmd.cs_n = st_r.cs_n;
  assign cmd.ras_n = st_r.code[2];
  assign cmd.cas_n = st_r.code[1];
  assign cmd.we_n = st_r.code[0];
  assign cmd.ba = st_r.ba;
  assign cmd.addr = st_r.addr;
endmodule : dpa_ctrl

// *** core/dpa_pkg.sv ***
// Package of the DDR2 precharge and auto-precharge block.
// Assumes one 200 MHz clock shared by the controller end and the device end.
package dpa_pkg;
  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_BANKS = 8;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned CNT_W = 8;
  // ==========================================================================
  // Timing in picoseconds and clock period
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned T_RAS_PS = 45000;
  localparam int unsigned T_RTP_PS = 7500;
  localparam int unsigned T_RP_PS = 15000;
  localparam int unsigned T_RC_PS = 60000;
  localparam int unsigned T_WR_PS = 15000;
  localparam int unsigned T_RCD_PS = 15000;
  // Minimum times round up to whole clocks.
  localparam int unsigned RAS_CYC = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RTP_CYC = (T_RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RC_CYC = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WR_CYC = (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RCD_CYC = (T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ==========================================================================
  // Reset values of the latency settings
  localparam logic [3:0] CL_RST = 4'h3;
  localparam logic [3:0] AL_RST = 4'h0;
  localparam logic [3:0] WR_RST = 4'h3;
  localparam logic BL8_RST = 1'b0;
  // ==========================================================================
  // Commands as {ras_n, cas_n, we_n} with chip select low
  typedef enum logic [2:0] {
    DPA_CMD_ACT = 3'h3,
    DPA_CMD_RD = 3'h5,
    DPA_CMD_WR = 3'h4,
    DPA_CMD_PRE = 3'h2,
    DPA_CMD_NOP = 3'h7
  } dpa_cmd_e;
  // ==========================================================================
  // Read latency is AL plus CL; write latency is one less.
  function automatic logic [CNT_W-1:0] dpa_rl(input logic [3:0] al, input logic [3:0] cl);
    dpa_rl = CNT_W'(al) + CNT_W'(cl);
  endfunction : dpa_rl
  function automatic logic [CNT_W-1:0] dpa_wl(input logic [3:0] al, input logic [3:0] cl);
    dpa_wl = dpa_rl(al, cl) - CNT_W'(1);
  endfunction : dpa_wl
  function automatic logic [CNT_W-1:0] dpa_half_bl(input logic bl8);
    dpa_half_bl = bl8 ? CNT_W'(4) : CNT_W'(2);
  endfunction : dpa_half_bl
  function automatic logic [CNT_W-1:0] dpa_max(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
    dpa_max = (a > b) ? a : b;
  endfunction : dpa_max
endpackage : dpa_pkg

// *** core/dpa_cmd_if.sv ***
// Command bus between the memory controller end and the device end.
// Assumes both ends run on the same clock; no clocking block.
interface dpa_cmd_if;
  import dpa_pkg::*;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  modport ctrl (output cs_n, output ras_n, output cas_n, output we_n, output ba, output addr);
  modport dev (input cs_n, input ras_n, input cas_n, input we_n, input ba, input addr);
endinterface : dpa_cmd_if

// *** core/dpa_bank.sv ***
// One bank's open state, active timer and auto-precharge scheduler.
// Assumes decoded one-cycle strobes from the device end on the same clock.
module dpa_bank
  import dpa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic act_i,
  input wire logic pre_i,
  input wire logic rd_ap_i,
  input wire logic wr_ap_i,
  input wire logic [CNT_W-1:0] rd_delay_i,
  input wire logic [CNT_W-1:0] rtp_floor_i,
  input wire logic [CNT_W-1:0] wr_delay_i,
  output logic open_o,
  output logic ap_pend_o,
  output logic ap_start_o
);
  import dpa_pkg::*;
  typedef struct packed {
    logic open;
    logic pend;
    logic [CNT_W-1:0] ras_cnt;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] rtp_cnt;
    logic start;
  } dpa_bank_s;
  dpa_bank_s st_r;
  dpa_bank_s st_nxt;
  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    if (st_r.ras_cnt != '0)
    begin
      st_nxt.ras_cnt = st_r.ras_cnt - CNT_W'(1);
    end
    if (st_r.wait_cnt != '0)
    begin
      st_nxt.wait_cnt = st_r.wait_cnt - CNT_W'(1);
    end
    if (st_r.rtp_cnt != '0)
    begin
      st_nxt.rtp_cnt = st_r.rtp_cnt - CNT_W'(1);
    end
    // The start waits until the row restore is done and every delay ran out.
    if (st_r.pend && st_r.wait_cnt <= CNT_W'(1) && st_r.ras_cnt <= CNT_W'(1)
        && st_r.rtp_cnt <= CNT_W'(1))
    begin
      st_nxt.pend = 1'b0;
      st_nxt.open = 1'b0;
      st_nxt.start = 1'b1;
    end
    if (act_i)
    begin
      st_nxt.open = 1'b1;
      st_nxt.ras_cnt = CNT_W'(RAS_CYC);
    end
    else if (pre_i && !st_r.pend)
    begin
      st_nxt.open = 1'b0;
    end
    if (rd_ap_i && st_r.open)
    begin
      st_nxt.pend = 1'b1;
      st_nxt.wait_cnt = rd_delay_i;
      st_nxt.rtp_cnt = rtp_floor_i;
    end
    else if (wr_ap_i && st_r.open)
    begin
      st_nxt.pend = 1'b1;
      st_nxt.wait_cnt = wr_delay_i;
      st_nxt.rtp_cnt = '0;
    end
  end
  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  assign open_o = st_r.open;
  assign ap_pend_o = st_r.pend;
  assign ap_start_o = st_r.start;
endmodule : dpa_bank

// *** core/dpa_dev.sv ***
// Device end: decodes commands and runs per-bank precharge and auto-precharge.
// Assumes the controller keeps its own spacing; inputs share the device clock.
// Behaviour
// - Precharge is CS, RAS, WE low, CAS high.
// - A10 low: one bank; high: all.
// - Read to precharge spacing kept by controller.
// - Earliest read precharge AL plus BL/2.
// - Read precharge time counts from last prefetch.
// - Write to precharge allows write recovery.
// - Precharge never interrupts write recovery.
// - A10 with read or write requests auto-precharge.
// - Close bank before opening another row.
// - Read auto-precharge after AL+BL/2, ras, rtp.
// - Read AP to activate: AL+tRTP+tRP.
// - Never before two clocks after last prefetch.
// - Reactivate after tRP and row cycle.
// - Write auto-precharge after burst plus WR.
// - Write AP reactivate after WR+tRP, tRC.
// - Auto-precharge waits for array restore.
// - Read latency is AL plus CL.
// - Write latency is read latency minus one.
// - RTP cycles are tRTP rounded up.
module dpa_dev
  import dpa_pkg::*;
#(
  parameter int unsigned BANKS = NUM_BANKS
)
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  dpa_cmd_if.dev cmd,
  input wire logic [3:0] cl_i,
  input wire logic [3:0] al_i,
  input wire logic [3:0] wr_i,
  input wire logic bl8_i,
  output logic [NUM_BANKS-1:0] bank_open_o,
  output logic [NUM_BANKS-1:0] ap_pend_o,
  output logic [NUM_BANKS-1:0] ap_start_o
);
  import dpa_pkg::*;
  if (BANKS != NUM_BANKS)
  begin : g_bad
    $error("dpa_dev serves eight banks only");
  end
  logic [2:0] cmd_code;
  logic sel;
  logic [NUM_BANKS-1:0] tgt;
  logic [NUM_BANKS-1:0] act_v;
  logic [NUM_BANKS-1:0] pre_v;
  logic [NUM_BANKS-1:0] rdap_v;
  logic [NUM_BANKS-1:0] wrap_v;
  logic [CNT_W-1:0] half_bl;
  logic [CNT_W-1:0] rd_delay;
  logic [CNT_W-1:0] rtp_floor;
  logic [CNT_W-1:0] wr_delay;
  // ==========================================================================
  // Decode
  assign cmd_code = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign sel = !cmd.cs_n;
  assign tgt = NUM_BANKS'(1) << cmd.ba;
  always_comb
  begin
    act_v = '0;
    pre_v = '0;
    rdap_v = '0;
    wrap_v = '0;
    if (sel)
    begin
      case (cmd_code)
        DPA_CMD_ACT: act_v = tgt;
        DPA_CMD_PRE: pre_v = cmd.addr[AP_BIT] ? '1 : tgt;
        DPA_CMD_RD: rdap_v = cmd.addr[AP_BIT] ? tgt : '0;
        DPA_CMD_WR: wrap_v = cmd.addr[AP_BIT] ? tgt : '0;
        default: act_v = '0;
      endcase
    end
  end
  // ==========================================================================
  // Auto-precharge delays; the last prefetch is AL, or AL plus 2 for BL8.
  assign half_bl = dpa_half_bl(bl8_i);
  assign rd_delay = CNT_W'(al_i) + half_bl;
  assign rtp_floor = CNT_W'(al_i) + (bl8_i ? CNT_W'(2) : CNT_W'(0))
                     + dpa_max(CNT_W'(RTP_CYC), CNT_W'(2));
  assign wr_delay = dpa_wl(al_i, cl_i) + half_bl + CNT_W'(wr_i);
  // ==========================================================================
  // Banks
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    dpa_bank u_bank (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .act_i(act_v[b]),
      .pre_i(pre_v[b]),
      .rd_ap_i(rdap_v[b]),
      .wr_ap_i(wrap_v[b]),
      .rd_delay_i(rd_delay),
      .rtp_floor_i(rtp_floor),
      .wr_delay_i(wr_delay),
      .open_o(bank_open_o[b]),
      .ap_pend_o(ap_pend_o[b]),
      .ap_start_o(ap_start_o[b])
    );
  end
endmodule : dpa_dev

// *** verif/dpa_chk.sv ***
// Checker of the command bus and the device end's bank outputs.
// Assumes one clock; the bench top instantiates it beside the interface.
module dpa_chk
  import dpa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [NUM_BANKS-1:0] bank_open_o,
  input wire logic [NUM_BANKS-1:0] ap_pend_o,
  input wire logic [NUM_BANKS-1:0] ap_start_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pre;
  logic act;
  logic col;
  assign pre = !cs_n && !ras_n && cas_n && !we_n;
  assign act = !cs_n && !ras_n && cas_n && we_n;
  assign col = !cs_n && ras_n && !cas_n;
  // ==========================================================================
  // Assertions
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  chk_pre_one_bank: assert property (pre && !addr[10] && !ap_pend_o[ba] |=>
    !bank_open_o[$past(ba)]) else $error("single bank precharge left bank open");
  chk_pre_all_banks: assert property (pre && addr[10] |=>
    (bank_open_o & ~$past(ap_pend_o)) == '0) else $error("precharge all left a bank open");
  chk_act_opens: assert property (act |=> bank_open_o[$past(ba)])
    else $error("activate did not open bank");
  chk_act_on_idle: assert property (act |-> !bank_open_o[ba])
    else $error("activate to an open bank");
  chk_ap_flag_set: assert property (col && addr[10] && bank_open_o[ba] |=>
    ap_pend_o[$past(ba)]) else $error("auto precharge not pending");
  chk_no_ap_keeps: assert property (col && !addr[10] && bank_open_o[ba] && !ap_pend_o[ba]
    |=> bank_open_o[$past(ba)] && !ap_pend_o[$past(ba)]) else $error("plain access closed bank");
  // The start may come no sooner than three clocks after the access edge.
  chk_ap_not_early: assert property (col && addr[10] && bank_open_o[ba] |=>
    !ap_start_o[$past(ba)] ##1 !ap_start_o[$past(ba, 2)])
    else $error("auto precharge started too early");
  chk_ap_bounded: assert property ((ap_pend_o & ~$past(ap_pend_o)) != '0 |->
    ##[1:16] ap_start_o != '0) else $error("auto precharge never started");
  chk_start_closes: assert property (ap_start_o != '0 |->
    (ap_start_o & bank_open_o) == '0) else $error("auto precharge bank still open");
  cover property (pre && addr[10]);
  cover property (act);
  cover property (ap_start_o != '0);
endmodule : dpa_chk

// *** verif/ddr2_precharge_autoprecharge_tb.sv ***
// Testbench joining the controller end and the device end over the bus.
// Assumes the package constants; one 200 MHz clock drives both ends.
module ddr2_precharge_autoprecharge_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpa_pkg::*;
  logic core_clk_i;
  logic resetn_i;
  logic req_valid;
  logic req_ap;
  logic req_ready;
  logic bl8;
  logic [2:0] req_cmd;
  logic [BANK_W-1:0] req_bank;
  logic [ADDR_W-1:0] req_addr;
  logic [3:0] cl;
  logic [3:0] al;
  logic [3:0] wr;
  logic [NUM_BANKS-1:0] bank_open;
  logic [NUM_BANKS-1:0] ap_pend;
  logic [NUM_BANKS-1:0] ap_start;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  dpa_cmd_if u_dpa_cmd_if();
  dpa_ctrl u_dpa_ctrl(.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cmd(u_dpa_cmd_if.ctrl),
    .req_valid_i(req_valid), .req_cmd_i(req_cmd), .req_bank_i(req_bank),
    .req_addr_i(req_addr), .req_ap_i(req_ap), .cl_i(cl), .al_i(al), .bl8_i(bl8),
    .req_ready_o(req_ready));
  dpa_dev u_dpa_dev(.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cmd(u_dpa_cmd_if.dev),
    .cl_i(cl), .al_i(al), .wr_i(wr), .bl8_i(bl8), .bank_open_o(bank_open),
    .ap_pend_o(ap_pend), .ap_start_o(ap_start));
  dpa_chk u_dpa_chk(.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cs_n(u_dpa_cmd_if.cs_n),
    .ras_n(u_dpa_cmd_if.ras_n), .cas_n(u_dpa_cmd_if.cas_n), .we_n(u_dpa_cmd_if.we_n),
    .ba(u_dpa_cmd_if.ba), .addr(u_dpa_cmd_if.addr), .bank_open_o(bank_open),
    .ap_pend_o(ap_pend), .ap_start_o(ap_start));
  // ==========================================================================
  // Clock and hang guard
  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Tasks
  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Entered at a falling edge; the request is held until the controller takes it.
  // One clock edge passes with valid low, so back-to-back calls never merge.
  task automatic req(input dpa_cmd_e c, input int b, input logic a);
    int n;
    n = 0;
    req_cmd = c;
    req_bank = b[2:0];
    req_ap = a;
    req_addr = {3'h0, a, 10'h000};
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1 && n < 200)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 200)
      err_total++;
    @(negedge core_clk_i);
    req_valid = 1'b0;
    @(negedge core_clk_i);
  endtask : req
  task automatic settle();
    repeat (3) @(negedge core_clk_i);
  endtask : settle
  // Opens a bank, then reads or writes it with auto-precharge and counts start pulses.
  // Lat is the number of clocks from the access on the bus to the internal start.
  task automatic ap_run(input dpa_cmd_e c, input int b, input int lat);
    int p;
    int at;
    p = 0;
    at = 0;
    req(DPA_CMD_ACT, b, 1'b0);
    req(c, b, 1'b1);
    repeat (2) @(negedge core_clk_i);
    cmp("pending", 8'h01, {7'h00, ap_pend[b]});
    // A pulse seen in pass k was registered k + 3 clocks after the device took the access.
    for (int k = 0; k < 40; k++)
    begin
      @(negedge core_clk_i);
      if (ap_start[b] === 1'b1)
      begin
        p++;
        at = k + 3;
      end
    end
    cmp("pulses", 8'h01, p[7:0]);
    cmp("start", lat[7:0], at[7:0]);
    cmp("closed", 8'h00, {7'h00, bank_open[b] | ap_pend[b]});
  endtask : ap_run
  // ==========================================================================
  // Sequence
  initial
  begin
    resetn_i = 1'b0;
    req_valid = 1'b0;
    req_cmd = DPA_CMD_NOP;
    req_bank = '0;
    req_ap = 1'b0;
    req_addr = '0;
    cl = 4'h3;
    al = 4'h0;
    wr = 4'h3;
    bl8 = 1'b0;
    repeat (10) @(negedge core_clk_i);
    resetn_i = 1'b1;
    cmp("open", 8'h00, bank_open);
    for (int i = 0; i < 8; i++)
      req(DPA_CMD_ACT, i, 1'b0);
    settle();
    cmp("open", 8'hFF, bank_open);
    req(DPA_CMD_PRE, 3, 1'b0);
    settle();
    cmp("open", 8'hF7, bank_open);
    req(DPA_CMD_PRE, 5, 1'b1);
    settle();
    cmp("open", 8'h00, bank_open);
    req(DPA_CMD_ACT, 2, 1'b0);
    req(DPA_CMD_RD, 2, 1'b0);
    req(DPA_CMD_WR, 2, 1'b0);
    repeat (20) @(negedge core_clk_i);
    cmp("open", 8'h04, bank_open);
    cmp("pending", 8'h00, ap_pend);
    req(DPA_CMD_PRE, 2, 1'b0);
    settle();
    // The access follows its activate by the row-to-column delay, so the row-active time rules.
    ap_run(DPA_CMD_RD, 1, RAS_CYC - RCD_CYC);
    bl8 = 1'b1;
    ap_run(DPA_CMD_WR, 6, int'(al) + int'(cl) - 1 + 4 + int'(wr));
    req(DPA_CMD_ACT, 1, 1'b0);
    req(DPA_CMD_ACT, 6, 1'b0);
    settle();
    cmp("open", 8'h42, bank_open);
    al = 4'h2;
    ap_run(DPA_CMD_RD, 3, int'(al) + 4);
    ap_run(DPA_CMD_WR, 4, int'(al) + int'(cl) - 1 + 4 + int'(wr));
    resetn_i = 1'b0;
    @(negedge core_clk_i);
    cmp("open", 8'h00, bank_open);
    resetn_i = 1'b1;
    req(DPA_CMD_ACT, 0, 1'b0);
    settle();
    cmp("open", 8'h01, bank_open);
    end_of_test();
  end
endmodule : ddr2_precharge_autoprecharge_tb
